// ### serial_char_pkg.sv
// package: register map, field layouts and modes of the serial character block
package serial_char_pkg;
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] MODE_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] RXDATA_OFS = 12'h00C;
  localparam logic [11:0] TXHOLD_OFS = 12'h010;
  localparam logic [11:0] GUARD_OFS = 12'h014;
  localparam logic [11:0] IDLE_OFS = 12'h018;
  localparam logic [11:0] BAUD_OFS = 12'h01C;
  // command bit positions
  localparam int CMD_TXEN = 0;
  localparam int CMD_RXEN = 1;
  localparam int CMD_CLRSTA = 2;
  localparam int CMD_SEND_ADDRESS_CMD = 3;
  localparam int CMD_ARM = 4;
  localparam int CMD_RELOAD = 5;
  // parity select encodings
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_NONE = 3'h4;
  localparam logic [2:0] PAR_MDROP0 = 3'h6;
  localparam logic [2:0] PAR_MDROP1 = 3'h7;
  localparam logic [15:0] BAUD_RESET = 16'h0010;
  localparam logic [3:0] OVERSAMPLE = 4'hF;
  localparam logic [3:0] HALF_SAMPLE = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;
  typedef struct packed {
    logic timeout;
    logic frameErr;
    logic rxBreak;
    logic parityErr;
    logic rxReady;
    logic txAllDone;
    logic txHoldingFree;
  } status_t;
endpackage

// ### serial_char_parity_timeguard_timeout.sv
// serial transceiver: parity, multidrop, timeguard, idle time-out, framing
// Operation
// R1 - even parity: bit is 0 for even count of ones, 1 for odd
// R2 - odd parity: bit is 1 for even count of ones, 0 for odd
// R3 - receiver flags parity bit breaking the even/odd rule
// R4 - mark parity sends 1; receiving 0 is a parity error
// R5 - space parity sends 0; receiving 1 is a parity error
// R6 - no parity: no bit sent, never a parity error
// R7 - parity error flag sticks until clear-status command
// R8 - parity encodings 6 and 7 select multidrop operation
// R9 - multidrop sends data with ninth bit 0, address with 1
// R10 - multidrop receiver flags parity error on high ninth bit
// R11 - send-address command makes next written character go out as address
// R12 - zero guard time adds no idle time
// R13 - nonzero guard holds line high that many extra bit periods
// R14 - holding-free stays low through guard if a character waits
// R15 - all-done flag stays low until guard time ends
// R16 - zero idle limit disables time-out, flag stays 0
// R17 - idle counter loads limit, counts bit periods, reloads per character
// R18 - counter reaching zero raises time-out flag
// R19 - arm command stops counting until the next character arrives
// R20 - reload command reloads and counts at once, no character needed
// R21 - stop bit sampled low is a framing error
// R22 - framing flag set mid stop bit, cleared by clear-status
// R23 - all-zero character with low stop is a break, not framing error; code also needs the parity bit low when parity is on
// R24 - restart commands clear time-out flag; guard field is eight bits
`timescale 1ns/100ps
module serial_char_parity_timeguard_timeout #(
  parameter int IDLE_W = 16,
  parameter int GUARD_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxLine,
  output logic txLine
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic wrStb;
  logic rdStb;
  logic [2:0] paritySelect_reg;
  logic [GUARD_W-1:0] guardTime_reg;
  logic [IDLE_W-1:0] idleLimit_reg;
  logic [15:0] baudDiv_reg;
  logic txEnable_reg;
  logic rxEnable_reg;
  logic sendAddr_reg;
  logic [7:0] holdData_reg;
  logic holdAddr_reg;
  logic holdFull_reg;
  logic [7:0] rxData_reg;
  serial_char_pkg::status_t status;
  logic cmdWr;
  logic clearStatus;
  logic armCmd;
  logic reloadCmd;

  assign wrStb = psel && penable && pwrite;
  assign rdStb = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign cmdWr = wrStb && paddr == serial_char_pkg::CMD_OFS;
  assign clearStatus = cmdWr && pwdata[serial_char_pkg::CMD_CLRSTA];
  assign armCmd = cmdWr && pwdata[serial_char_pkg::CMD_ARM];
  assign reloadCmd = cmdWr && pwdata[serial_char_pkg::CMD_RELOAD];
  assign pslverr = psel && penable &&
    (paddr > serial_char_pkg::BAUD_OFS || paddr[1:0] != 2'h0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      paritySelect_reg <= serial_char_pkg::PAR_EVEN;
      guardTime_reg <= '0;
      idleLimit_reg <= '0;
      baudDiv_reg <= serial_char_pkg::BAUD_RESET;
      txEnable_reg <= 1'b0;
      rxEnable_reg <= 1'b0;
    end else if (wrStb) begin
      case (paddr)
        serial_char_pkg::MODE_OFS: paritySelect_reg <= pwdata[2:0];
        serial_char_pkg::GUARD_OFS: guardTime_reg <= pwdata[GUARD_W-1:0]; // R24
        serial_char_pkg::IDLE_OFS: idleLimit_reg <= pwdata[IDLE_W-1:0];
        serial_char_pkg::BAUD_OFS: baudDiv_reg <= pwdata[15:0];
        serial_char_pkg::CMD_OFS: begin
          txEnable_reg <= pwdata[serial_char_pkg::CMD_TXEN];
          rxEnable_reg <= pwdata[serial_char_pkg::CMD_RXEN];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        serial_char_pkg::MODE_OFS: prdata <= {29'h0, paritySelect_reg};
        serial_char_pkg::STATUS_OFS: prdata <= {25'h0, status};
        serial_char_pkg::RXDATA_OFS: prdata <= {24'h0, rxData_reg};
        serial_char_pkg::GUARD_OFS:
          prdata <= {{(32-GUARD_W){1'b0}}, guardTime_reg};
        serial_char_pkg::IDLE_OFS:
          prdata <= {{(32-IDLE_W){1'b0}}, idleLimit_reg};
        serial_char_pkg::BAUD_OFS: prdata <= {16'h0, baudDiv_reg};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // baud ticks: 16 samples a bit
  // ----------------------------------------------------------------
  logic [15:0] baudCnt_reg;
  logic sampleTick;
  logic [3:0] txSub_reg;
  logic bitTick;
  assign sampleTick = baudCnt_reg == '0;
  assign bitTick = sampleTick && txSub_reg == '0;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_reg <= '0;
    end else if (sampleTick) begin
      baudCnt_reg <= baudDiv_reg - 16'h0001;
    end else begin
      baudCnt_reg <= baudCnt_reg - 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txSub_reg <= '0;
    end else if (sampleTick) begin
      txSub_reg <= txSub_reg - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // parity generation
  // ----------------------------------------------------------------
  function automatic logic parityOf(input logic [2:0] sel,
                                    input logic [7:0] d, input logic addr);
    logic p;
    p = 1'b0;
    case (sel)
      serial_char_pkg::PAR_EVEN: p = ^d; // R1
      serial_char_pkg::PAR_ODD: p = ~^d; // R2
      serial_char_pkg::PAR_MARK: p = 1'b1; // R4
      serial_char_pkg::PAR_SPACE: p = 1'b0; // R5
      serial_char_pkg::PAR_MDROP0, serial_char_pkg::PAR_MDROP1: p = addr; // R8 R9
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
    TX_PARITY = 6'h08, TX_STOP = 6'h10, TX_GUARD = 6'h20
  } tx_state_t;
  tx_state_t txState_reg;
  logic [7:0] txShift_reg;
  logic txPar_reg;
  logic [3:0] txBit_reg;
  logic [GUARD_W-1:0] guardCnt_reg;
  logic holdWrite;
  logic txLoad;
  logic parityOn;
  assign parityOn = paritySelect_reg != serial_char_pkg::PAR_NONE &&
                    paritySelect_reg != 3'h5;
  // a write while the holding slot is full is dropped
  assign holdWrite = wrStb && paddr == serial_char_pkg::TXHOLD_OFS &&
                     txEnable_reg && !holdFull_reg;
  assign txLoad = bitTick && holdFull_reg && txState_reg == TX_IDLE;
  logic stopLoad;
  assign stopLoad = bitTick && holdFull_reg &&
    (txState_reg == TX_STOP ? guardTime_reg == '0 :
     txState_reg == TX_GUARD && guardCnt_reg == '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sendAddr_reg <= 1'b0;
    end else if (cmdWr && pwdata[serial_char_pkg::CMD_SEND_ADDRESS_CMD]) begin
      sendAddr_reg <= 1'b1; // R11
    end else if (holdWrite) begin
      sendAddr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      holdFull_reg <= 1'b0;
      holdData_reg <= '0;
      holdAddr_reg <= 1'b0;
    end else if (holdWrite) begin
      holdFull_reg <= 1'b1;
      holdData_reg <= pwdata[7:0];
      holdAddr_reg <= sendAddr_reg; // R11
    end else if (txLoad || stopLoad) begin
      holdFull_reg <= 1'b0; // R14
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txState_reg <= TX_IDLE;
      txShift_reg <= '0;
      txPar_reg <= 1'b0;
      txBit_reg <= '0;
      guardCnt_reg <= '0;
      txLine <= 1'b1;
    end else if (bitTick) begin
      case (txState_reg)
        TX_IDLE: begin
          txLine <= 1'b1;
          if (holdFull_reg) begin
            txShift_reg <= holdData_reg;
            txPar_reg <= parityOf(paritySelect_reg, holdData_reg,
                                  holdAddr_reg);
            txLine <= 1'b0;
            txState_reg <= TX_START;
          end
        end
        TX_START: begin
          txLine <= txShift_reg[0];
          txShift_reg <= {1'b0, txShift_reg[7:1]};
          txBit_reg <= serial_char_pkg::DATA_BITS - 4'h1;
          txState_reg <= TX_DATA;
        end
        TX_DATA: begin
          if (txBit_reg != '0) begin
            txLine <= txShift_reg[0];
            txShift_reg <= {1'b0, txShift_reg[7:1]};
            txBit_reg <= txBit_reg - 4'h1;
          end else if (parityOn) begin
            txLine <= txPar_reg;
            txState_reg <= TX_PARITY;
          end else begin
            txLine <= 1'b1; // R6
            txState_reg <= TX_STOP;
          end
        end
        TX_PARITY: begin
          txLine <= 1'b1;
          txState_reg <= TX_STOP;
        end
        TX_STOP, TX_GUARD: begin
          txLine <= 1'b1; // R13
          if (txState_reg == TX_STOP && guardTime_reg != '0) begin
            guardCnt_reg <= guardTime_reg - 1'b1;
            txState_reg <= TX_GUARD;
          end else if (txState_reg == TX_GUARD && guardCnt_reg != '0) begin
            guardCnt_reg <= guardCnt_reg - 1'b1;
          end else if (holdFull_reg) begin
            txShift_reg <= holdData_reg; // R12 R14
            txPar_reg <= parityOf(paritySelect_reg, holdData_reg,
                                  holdAddr_reg);
            txLine <= 1'b0;
            txState_reg <= TX_START;
          end else begin
            txState_reg <= TX_IDLE;
          end
        end
        default: txState_reg <= TX_IDLE;
      endcase
    end
  end

  assign status.txHoldingFree = txEnable_reg && !holdFull_reg; // R14
  assign status.txAllDone = txEnable_reg && !holdFull_reg &&
                            txState_reg == TX_IDLE; // R15

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PARITY = 5'h08, RX_STOP = 5'h10
  } rx_state_t;
  rx_state_t rxState_reg;
  logic [3:0] rxSub_reg;
  logic [3:0] rxBit_reg;
  logic [7:0] rxShift_reg;
  logic rxPar_reg;
  logic rxMid;
  logic rxDone;
  logic parErrEvt;
  logic frameEvt;
  logic breakEvt;
  logic rxReady_reg;
  logic parErr_reg;
  logic frameErr_reg;
  logic rxBreak_reg;
  assign rxMid = sampleTick && rxSub_reg == '0;
  assign rxDone = rxMid && rxState_reg == RX_STOP;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxState_reg <= RX_IDLE;
      rxSub_reg <= '0;
      rxBit_reg <= '0;
      rxShift_reg <= '0;
      rxPar_reg <= 1'b0;
    end else if (sampleTick) begin
      rxSub_reg <= rxSub_reg - 4'h1;
      case (rxState_reg)
        RX_IDLE: begin
          if (rxEnable_reg && !rxLine) begin
            rxSub_reg <= serial_char_pkg::HALF_SAMPLE;
            rxState_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rxSub_reg == '0) begin
            rxSub_reg <= serial_char_pkg::OVERSAMPLE;
            rxBit_reg <= serial_char_pkg::DATA_BITS - 4'h1;
            rxState_reg <= rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSub_reg == '0) begin
            rxShift_reg <= {rxLine, rxShift_reg[7:1]};
            rxBit_reg <= rxBit_reg - 4'h1;
            if (rxBit_reg == '0) begin
              rxState_reg <= parityOn ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rxSub_reg == '0) begin
            rxPar_reg <= rxLine;
            rxState_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxSub_reg == '0) begin
            rxState_reg <= RX_IDLE;
          end
        end
        default: rxState_reg <= RX_IDLE;
      endcase
    end
  end

  always_comb begin
    parErrEvt = 1'b0;
    if (rxDone) begin
      case (paritySelect_reg)
        serial_char_pkg::PAR_EVEN:
          parErrEvt = rxPar_reg != ^rxShift_reg; // R3
        serial_char_pkg::PAR_ODD:
          parErrEvt = rxPar_reg != ~^rxShift_reg; // R3
        serial_char_pkg::PAR_MARK: parErrEvt = !rxPar_reg; // R4
        serial_char_pkg::PAR_SPACE: parErrEvt = rxPar_reg; // R5
        serial_char_pkg::PAR_MDROP0, serial_char_pkg::PAR_MDROP1:
          parErrEvt = rxPar_reg; // R8 R10
        default: parErrEvt = 1'b0; // R6
      endcase
    end
  end
  assign breakEvt = rxDone && !rxLine && rxShift_reg == '0 &&
                    (!parityOn || !rxPar_reg); // R23
  assign frameEvt = rxDone && !rxLine && !breakEvt; // R21

  // set wins over clear on the parity, framing and break flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parErr_reg <= 1'b0;
      frameErr_reg <= 1'b0;
      rxBreak_reg <= 1'b0;
    end else begin
      parErr_reg <= parErrEvt || (parErr_reg && !clearStatus); // R7
      frameErr_reg <= frameEvt || (frameErr_reg && !clearStatus); // R22
      rxBreak_reg <= breakEvt || (rxBreak_reg && !clearStatus);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxData_reg <= '0;
      rxReady_reg <= 1'b0;
    end else if (rxDone) begin
      rxData_reg <= rxShift_reg;
      rxReady_reg <= 1'b1;
    end else if (rdStb && paddr == serial_char_pkg::RXDATA_OFS) begin
      rxReady_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // idle time-out
  // ----------------------------------------------------------------
  logic [IDLE_W-1:0] idleCnt_reg;
  logic idleRun_reg;
  logic timeout_reg;
  logic idleZero;
  assign idleZero = idleRun_reg && bitTick && idleCnt_reg == 1;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt_reg <= '0;
      idleRun_reg <= 1'b0;
    end else if (idleLimit_reg == '0) begin
      idleRun_reg <= 1'b0; // R16
    end else if (reloadCmd || rxDone) begin
      idleCnt_reg <= idleLimit_reg; // R17 R20
      idleRun_reg <= 1'b1;
    end else if (armCmd) begin
      idleCnt_reg <= idleLimit_reg; // R19
      idleRun_reg <= 1'b0;
    end else if (idleRun_reg && bitTick) begin
      idleCnt_reg <= idleCnt_reg - 1'b1; // R17
      if (idleZero) begin
        idleRun_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timeout_reg <= 1'b0;
    end else if (idleLimit_reg == '0) begin
      timeout_reg <= 1'b0; // R16
    end else begin
      timeout_reg <= (idleZero && !armCmd && !reloadCmd && !rxDone) ||
                     (timeout_reg && !armCmd && !reloadCmd); // R18 R24
    end
  end

  assign status.timeout = timeout_reg;
  assign status.frameErr = frameErr_reg;
  assign status.rxBreak = rxBreak_reg;
  assign status.parityErr = parErr_reg;
  assign status.rxReady = rxReady_reg;
endmodule // serial_char_parity_timeguard_timeout

// ### serial_char_monitor.sv
// checker: frame shape and status relations seen at the block's pins
`timescale 1ns/100ps
module serial_char_monitor #(
  parameter int IDLE_W = 16,
  parameter int GUARD_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxLine,
  input wire logic txLine
);
  logic [2:0] parMode;
  logic [GUARD_W-1:0] guardBits;
  logic [IDLE_W-1:0] idleLim;
  logic [15:0] baud;
  logic sawAddr;
  logic inFrame;
  logic [7:0] shiftData;
  logic wrAcc;
  logic rdStatus;
  logic mdrop;
  logic parOn;
  logic midBit;
  logic parSample;
  int cnt;
  int bitClks;
  int frameEnd;
  int stopMid;
  assign wrAcc = psel && penable && pwrite;
  assign rdStatus = psel && penable && !pwrite &&
                    paddr == serial_char_pkg::STATUS_OFS;
  assign mdrop = parMode[2:1] == 2'h3;
  assign parOn = parMode[2:1] != 2'h2;
  assign bitClks = 16 * int'(baud);
  // ends early: next start edge never missed
  assign frameEnd = (10 + int'(parOn) + int'(guardBits)) * bitClks - 2;
  assign stopMid = (9 + int'(parOn)) * bitClks + bitClks / 2;
  assign midBit = inFrame && (cnt % bitClks == bitClks / 2);
  assign parSample = midBit && cnt / bitClks == 9;
  // ------------------------------
  // shadow of the configuration
  // ------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parMode <= 3'h0;
      guardBits <= '0;
      idleLim <= '0;
      baud <= serial_char_pkg::BAUD_RESET;
      sawAddr <= 1'b0;
    end else if (wrAcc) begin
      case (paddr)
        serial_char_pkg::MODE_OFS: parMode <= pwdata[2:0];
        serial_char_pkg::GUARD_OFS: guardBits <= pwdata[GUARD_W-1:0];
        serial_char_pkg::IDLE_OFS: idleLim <= pwdata[IDLE_W-1:0];
        serial_char_pkg::BAUD_OFS: baud <= pwdata[15:0];
        default: ;
      endcase
      if (paddr == serial_char_pkg::MODE_OFS) sawAddr <= 1'b0;
      if (paddr == serial_char_pkg::CMD_OFS &&
          pwdata[serial_char_pkg::CMD_SEND_ADDRESS_CMD]) sawAddr <= 1'b1;
    end
  end
  // ------------------------------
  // transmit frame tracker
  // ------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inFrame <= 1'b0;
      cnt <= 0;
      shiftData <= 8'h00;
    end else if (!inFrame) begin
      inFrame <= !txLine;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt >= frameEnd) inFrame <= 1'b0;
      if (midBit && cnt / bitClks inside {[1:8]})
        shiftData <= {txLine, shiftData[7:1]};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_even_parity: assert property (
    parSample && parMode == serial_char_pkg::PAR_EVEN |-> txLine == ^shiftData)
    else $error("even parity bit wrong");
  a_odd_parity: assert property (
    parSample && parMode == serial_char_pkg::PAR_ODD |-> txLine == ~^shiftData)
    else $error("odd parity bit wrong");
  a_mark_parity: assert property (
    parSample && parMode == serial_char_pkg::PAR_MARK |-> txLine)
    else $error("mark parity bit low");
  a_space_parity: assert property (
    parSample && parMode == serial_char_pkg::PAR_SPACE |-> !txLine)
    else $error("space parity bit high");
  a_no_parity_stop: assert property (
    parSample && !parOn |-> txLine)
    else $error("extra bit sent without parity");
  a_mdrop_data: assert property (
    parSample && mdrop && !sawAddr |-> !txLine)
    else $error("data character sent with high ninth bit");
  a_guard_high: assert property (
    inFrame && cnt >= stopMid |-> txLine)
    else $error("line low during stop or guard");
  a_done_low_busy: assert property (
    rdStatus && $past(inFrame) && $past(inFrame, 2) |-> !prdata[1])
    else $error("all-done flag high mid character");
  a_timeout_off: assert property (
    rdStatus && idleLim == 0 && $past(idleLim, 2) == 0 |-> !prdata[6])
    else $error("time-out flag high with zero limit");
endmodule // serial_char_monitor

bind serial_char_parity_timeguard_timeout serial_char_monitor #(
  .IDLE_W(IDLE_W), .GUARD_W(GUARD_W)) mon (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxLine(rxLine), .txLine(txLine));

// ### serial_remote_model.sv
// remote serial device model facing the block's transmit and receive lines
`timescale 1ns/100ps
module serial_remote_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clock,
  input wire logic txLine,
  input wire logic parOn,
  output logic rxLine
);
  logic [10:0] frameBits = '0;
  int frames = 0;
  int span = 0;
  time lastStart = 0;
  initial rxLine = 1'b1;
  // ------------------------------
  // receive: mid-bit samples, ends mid stop
  // ------------------------------
  initial begin
    forever begin
      @(negedge txLine);
      span = int'(($time - lastStart) / 8);
      lastStart = $time;
      repeat (BIT_CLKS / 2) @(posedge clock);
      for (int i = 0; i < 10 + int'(parOn); i++) begin
        frameBits[i] = txLine;
        if (i < 9 + int'(parOn)) repeat (BIT_CLKS) @(posedge clock);
      end
      frames++;
    end
  end
  // ------------------------------
  // transmit: caller picks parity and stop
  // ------------------------------
  task automatic send_char(input logic [7:0] d, input logic p,
                           input logic usePar, input logic stopBit);
    logic [10:0] bits;
    bits = usePar ? {stopBit, p, d, 1'b0} : {1'b1, stopBit, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      rxLine <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge clock);
    end
    @(posedge clock);
    rxLine <= 1'b1;
    repeat (BIT_CLKS) @(posedge clock);
  endtask
endmodule // serial_remote_model

// ### tb_serial_char_parity_timeguard_timeout.sv
// testbench: APB register traffic and character exchange with the model
`timescale 1ns/100ps
module tb_serial_char_parity_timeguard_timeout;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] data;
    logic sa;
    logic rp;
    logic rs;
    logic tp;
    logic [2:0] st;
  } row_t;
  // mode, data, {addr, rx par, rx stop, bit 9}, rx flags
  row_t rows [11] = '{
    {3'h0, 8'h41, 4'h2, 3'h0}, {3'h0, 8'h07, 4'h3, 3'h1},
    {3'h1, 8'h41, 4'h7, 3'h0}, {3'h1, 8'h07, 4'h6, 3'h1},
    {3'h3, 8'h41, 4'h3, 3'h1}, {3'h2, 8'h41, 4'h6, 3'h1},
    {3'h4, 8'h41, 4'h3, 3'h0}, {3'h6, 8'h41, 4'hF, 3'h1},
    {3'h7, 8'h41, 4'h2, 3'h0}, {3'h0, 8'h41, 4'h0, 3'h4},
    {3'h0, 8'h00, 4'h0, 3'h2}
  };
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxLine;
  logic txLine;
  logic parOn = 1'b1;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int tests_run = 0;
  int n0;
  row_t r;
  serial_char_parity_timeguard_timeout DUT (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxLine(rxLine), .txLine(txLine));
  serial_remote_model #(.BIT_CLKS(16)) remote (.clock(clock),
    .txLine(txLine), .parOn(parOn), .rxLine(rxLine));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic ran_out();
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) ran_out();
    @(posedge clock);
  endtask
  task automatic cmd(input int b);
    apb(1'b1, serial_char_pkg::CMD_OFS, 32'h3 | (32'h1 << b));
  endtask
  task automatic rd_sta();
    apb(1'b0, serial_char_pkg::STATUS_OFS, 32'h0);
  endtask
  task automatic status_bit(input int b, input logic v);
    rd_sta();
    chk({31'h0, q[b]}, {31'h0, v});
  endtask
  task automatic poll(input int b);
    int i = 0;
    do begin
      rd_sta();
      i++;
    end while (q[b] !== 1'b1 && i < 300);
    if (q[b] !== 1'b1) ran_out();
  endtask
  task automatic wait_frames(input int n);
    int i = 0;
    while (remote.frames < n && i < 5000) begin
      @(posedge clock);
      i++;
    end
    if (i >= 5000) ran_out();
  endtask
  task automatic tx_pair(input logic [7:0] a, input logic [7:0] b);
    n0 = remote.frames;
    apb(1'b1, serial_char_pkg::TXHOLD_OFS, {24'h0, a});
    poll(0);
    apb(1'b1, serial_char_pkg::TXHOLD_OFS, {24'h0, b});
    wait_frames(n0 + 1);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, serial_char_pkg::BAUD_OFS, 32'h0);
    chk(q, {16'h0, serial_char_pkg::BAUD_RESET});
    apb(1'b0, 12'h020, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, serial_char_pkg::BAUD_OFS, 32'h1);
    cmd(0);
    foreach (rows[i]) begin
      r = rows[i];
      parOn <= r.mode[2:1] != 2'h2;
      apb(1'b1, serial_char_pkg::MODE_OFS, {29'h0, r.mode});
      if (r.sa) cmd(serial_char_pkg::CMD_SEND_ADDRESS_CMD);
      n0 = remote.frames;
      apb(1'b1, serial_char_pkg::TXHOLD_OFS, {24'h0, r.data});
      wait_frames(n0 + 1);
      chk({23'h0, remote.frameBits[9:1]}, {23'h0, r.tp, r.data});
      remote.send_char(r.data, r.rp, parOn, r.rs);
      rd_sta();
      chk({29'h0, q[5:3]}, {29'h0, r.st});
      apb(1'b0, serial_char_pkg::RXDATA_OFS, 32'h0);
      cmd(serial_char_pkg::CMD_CLRSTA);
      rd_sta();
      chk({29'h0, q[5:3]}, 32'h0);
    end
    // ------------------------------
    // guard time, with a second character waiting
    // ------------------------------
    parOn <= 1'b1;
    apb(1'b1, serial_char_pkg::MODE_OFS, 32'h0);
    apb(1'b1, serial_char_pkg::GUARD_OFS, 32'h3);
    tx_pair(8'h55, 8'hAA);
    repeat (16) @(posedge clock);
    rd_sta();
    chk({30'h0, q[1:0]}, 32'h0);
    wait_frames(n0 + 2);
    chk(remote.span, (11 + 3) * 16);
    apb(1'b1, serial_char_pkg::GUARD_OFS, 32'h0);
    poll(1);
    tx_pair(8'h0F, 8'hF0);
    wait_frames(n0 + 2);
    chk(remote.span, 11 * 16);
    // ------------------------------
    // idle time-out, 4 bit periods of 16 clocks
    // ------------------------------
    apb(1'b1, serial_char_pkg::IDLE_OFS, 32'h4);
    cmd(serial_char_pkg::CMD_RELOAD);
    repeat (32) @(posedge clock);
    status_bit(6, 1'b0);
    repeat (64) @(posedge clock);
    status_bit(6, 1'b1);
    cmd(serial_char_pkg::CMD_ARM);
    repeat (160) @(posedge clock);
    status_bit(6, 1'b0);
    remote.send_char(8'h41, 1'b0, 1'b1, 1'b1);
    repeat (16) @(posedge clock);
    status_bit(6, 1'b0);
    repeat (48) @(posedge clock);
    status_bit(6, 1'b1);
    apb(1'b1, serial_char_pkg::IDLE_OFS, 32'h0);
    repeat (8) @(posedge clock);
    status_bit(6, 1'b0);
    finish_test();
  end
endmodule // tb_serial_char_parity_timeguard_timeout
